// *** hw/dic_params.svh ***
// Offsets, field positions, reset values and timing counts of the register bank
`ifndef DIC_PARAMS_SVH
`define DIC_PARAMS_SVH
`define DIC_OFF_CODE 7'h01
`define DIC_OFF_CFG 7'h02
`define DIC_RST_CODE 16'h0000
`define DIC_RST_CFG 16'h0036
`define DIC_F_LIMIT 15:14
`define DIC_F_DIV 13:10
`define DIC_B_BRK_IRQ 9
`define DIC_B_PIN_EN 8
`define DIC_B_CLR_EN 7
`define DIC_B_UART_OFF 6
`define DIC_B_BAUD 5
`define DIC_B_CRC_EN 4
`define DIC_B_POL 3
`define DIC_B_TRIG 2
`define DIC_B_TRI 1
`define DIC_B_EARLY 0
`define DIC_B_READ 23
`define DIC_F_ADDR 22:16
`define DIC_PIN_RST 3'h2
`define DIC_FRAME_BITS 6'h18
`define DIC_FRAME_CRC_BITS 6'h20
`define DIC_CRC_POLY 8'h07
`define DIC_CRC_INIT 8'hFF
`define DIC_CLK_HZ 64'd200000000
`define DIC_CLK_PS 5000
`define DIC_OSC_HZ 64'd1228800
`define DIC_OSC_INC ((64'd2 * `DIC_OSC_HZ * 64'd16777216) / `DIC_CLK_HZ)
`define DIC_IRQ_PULSE_NS 100
`define DIC_IRQ_PULSE_CYC ((`DIC_IRQ_PULSE_NS * 1000 + `DIC_CLK_PS - 1) / `DIC_CLK_PS)
`endif

// *** hw/dic_pkg.sv ***
// Types shared by the register bank files
package dic_pkg;
   typedef logic [15:0] dic_word_t;
   typedef enum logic [1:0] {
      DIC_CLOCK_OUT_DIVIDER_OFF,
      DIC_CLOCK_OUT_DIVIDER_DIV,
      DIC_CLOCK_OUT_DIVIDER_LOW,
      DIC_CLOCK_OUT_DIVIDER_TIMER
   } dic_clock_out_divider_e;
endpackage

// *** hw/dic_sync.sv ***
// Two-stage synchroniser for the serial pins
`timescale 1ns/10ps
`include "dic_params.svh"
module dic_sync (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_sync_n,
   // Pins in, order sdi, cs_n, sclk
   input wire logic [2:0] pin_in,
   // Synchronised copy
   output logic [2:0] pin_out
);
   logic [2:0] meta_q;
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         meta_q <= `DIC_PIN_RST;
         pin_out <= `DIC_PIN_RST;
      end else begin
         meta_q <= pin_in;
         pin_out <= meta_q;
      end
   end
endmodule

// *** hw/dic_clkout.sv ***
// Oscillator timebase and clock-output pin selection
`timescale 1ns/10ps
`include "dic_params.svh"
module dic_clkout (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_sync_n,
   // Control
   input wire logic [3:0] clock_out_divider,
   input wire logic timer_out,
   // Pin
   output logic clk_out_o,
   output logic clk_out_oe
);
   localparam logic [23:0] OSC_INC = 24'(`DIC_OSC_INC);
   logic [23:0] phase_q;
   logic [24:0] phase_sum;
   logic [10:0] div_q;
   logic pin_d;
   dic_pkg::dic_clock_out_divider_e mode;
   // Edges jitter by one system clock; average rate runs about 2 ppm slow, as OSC_INC is truncated
   assign phase_sum = {1'b0, phase_q} + {1'b0, OSC_INC};
   assign mode = (clock_out_divider == 4'h0) ? dic_pkg::DIC_CLOCK_OUT_DIVIDER_OFF :
                 (clock_out_divider <= 4'hB) ? dic_pkg::DIC_CLOCK_OUT_DIVIDER_DIV :
                 (clock_out_divider == 4'hF) ? dic_pkg::DIC_CLOCK_OUT_DIVIDER_TIMER :
                 dic_pkg::DIC_CLOCK_OUT_DIVIDER_LOW;
   always_comb begin
      pin_d = 1'b0;
      unique case (mode)
         dic_pkg::DIC_CLOCK_OUT_DIVIDER_OFF: pin_d = 1'b0;
         dic_pkg::DIC_CLOCK_OUT_DIVIDER_DIV: pin_d = div_q[clock_out_divider - 4'h1];
         dic_pkg::DIC_CLOCK_OUT_DIVIDER_LOW: pin_d = 1'b0;
         dic_pkg::DIC_CLOCK_OUT_DIVIDER_TIMER: pin_d = timer_out;
      endcase
   end
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         phase_q <= 24'h000000;
         div_q <= 11'h000;
         clk_out_o <= 1'b0;
         clk_out_oe <= 1'b0;
      end else begin
         phase_q <= phase_sum[23:0];
         if (phase_sum[24]) begin
            div_q <= div_q + 11'h001;
         end
         clk_out_o <= pin_d;
         clk_out_oe <= (mode != dic_pkg::DIC_CLOCK_OUT_DIVIDER_OFF);
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync_n);
   clock_out_divider_off_a: assert property (clock_out_divider == 4'h0 |=> !clk_out_oe)
      else $error("clock pin enabled while off");
   clock_out_divider_tick_a: assert property (phase_sum[24] |=> !phase_sum[24] [*8])
      else $error("oscillator tick too fast");
   clock_out_divider_low_a: assert property (clock_out_divider inside {4'hC, 4'hD, 4'hE}
      |=> clk_out_oe && !clk_out_o)
      else $error("clock pin not held low");
   clock_out_divider_timer_a: assert property (clock_out_divider == 4'hF
      |=> clk_out_o == $past(timer_out))
      else $error("timer not routed to clock pin");
endmodule

// *** hw/dic_config_regs.sv ***
// Output code and interface configuration registers behind the SPI pins
`timescale 1ns/10ps
`include "dic_params.svh"
module dic_config_regs (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // SPI pins
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo_o,
   output logic spi_sdo_oe,
   // Interrupt source and pin
   input wire logic irq_event,
   output logic irq_pin_o,
   output logic irq_pin_oe,
   // Clock output pin
   input wire logic timer_out,
   output logic clk_out_o,
   output logic clk_out_oe,
   // CRC status
   input wire logic crc_error_clear,
   output logic crc_error,
   output logic crc_check_on,
   // Device controls
   output logic [15:0] output_code,
   output logic clear_active,
   output logic serial_port_enable,
   output logic break_mode_link,
   output logic serial_tx_pin_irq
);
   localparam logic [7:0] PULSE_CYC = 8'(`DIC_IRQ_PULSE_CYC);
   logic rst_meta_q;
   logic rst_sync_n_q;
   logic [2:0] pins_s;
   logic sclk_s;
   logic cs_n_s;
   logic sdi_s;
   logic sclk_last_q;
   logic cs_last_q;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   dic_pkg::dic_word_t code_q;
   dic_pkg::dic_word_t cfg_q;
   logic [31:0] rx_sh_q;
   logic [5:0] bit_cnt_q;
   logic [5:0] rx_cnt_next;
   logic [7:0] rx_crc_q;
   logic [23:0] cmd;
   dic_pkg::dic_word_t wdata;
   logic [6:0] addr;
   logic crc_en;
   logic len_ok;
   logic crc_pass;
   logic frame_ok;
   logic wr_en;
   logic rd_en;
   logic crc_fail_evt;
   logic crc_pass_evt;
   logic [31:0] tx_sh_q;
   logic [5:0] tx_idx_q;
   logic [5:0] tx_idx_next;
   logic [7:0] tx_crc_q;
   logic launched_q;
   logic tx_shift;
   logic tx_bit;
   logic [6:0] raddr_q;
   dic_pkg::dic_word_t rdata_q;
   logic [3:0] fail_cnt_q;
   logic [4:0] fail_next;
   logic [4:0] fail_limit;
   logic fail_hit;
   logic crc_error_q;
   logic irq_last_q;
   logic [7:0] pulse_q;
   logic irq_active;
   logic brk_mode;

   function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic din);
      logic fb;
      fb = crc[7] ^ din;
      crc_step = {crc[6:0], 1'b0} ^ (fb ? `DIC_CRC_POLY : 8'h00);
   endfunction

   function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
      hit = (a == off);
   endfunction

   // Reset release
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n_q <= rst_meta_q;
      end
   end

   dic_sync u_sync (
      .clock(clock),
      .rst_sync_n(rst_sync_n_q),
      .pin_in({spi_sdi, spi_cs_n, spi_sclk}),
      .pin_out(pins_s)
   );

   dic_clkout u_clkout (
      .clock(clock),
      .rst_sync_n(rst_sync_n_q),
      .clock_out_divider(cfg_q[`DIC_F_DIV]),
      .timer_out(timer_out),
      .clk_out_o(clk_out_o),
      .clk_out_oe(clk_out_oe)
   );

   // Pin edges
   assign sclk_s = pins_s[0];
   assign cs_n_s = pins_s[1];
   assign sdi_s = pins_s[2];
   assign sclk_rise = sclk_s && !sclk_last_q;
   assign sclk_fall = !sclk_s && sclk_last_q;
   assign cs_fall = !cs_n_s && cs_last_q;
   assign cs_rise = cs_n_s && !cs_last_q;

   always_ff @(posedge clock or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         sclk_last_q <= 1'b0;
         cs_last_q <= 1'b1;
      end else begin
         sclk_last_q <= sclk_s;
         cs_last_q <= cs_n_s;
      end
   end

   // Frame decode
   assign crc_en = cfg_q[`DIC_B_CRC_EN];
   assign rx_cnt_next = (bit_cnt_q == 6'h3F) ? bit_cnt_q : bit_cnt_q + 6'h01;
   assign len_ok = bit_cnt_q == (crc_en ? `DIC_FRAME_CRC_BITS : `DIC_FRAME_BITS);
   assign cmd = crc_en ? rx_sh_q[31:8] : rx_sh_q[23:0];
   assign wdata = cmd[15:0];
   assign addr = cmd[`DIC_F_ADDR];
   assign crc_pass = (rx_crc_q == rx_sh_q[7:0]);
   // Frames of the wrong length are dropped without touching the count
   assign frame_ok = cs_rise && len_ok && (!crc_en || crc_pass);
   assign crc_fail_evt = cs_rise && len_ok && crc_en && !crc_pass;
   assign crc_pass_evt = cs_rise && len_ok && crc_en && crc_pass;
   assign wr_en = frame_ok && !cmd[`DIC_B_READ];
   assign rd_en = frame_ok && cmd[`DIC_B_READ];

   // Receive shifter, SDI taken on falling SCLK
   always_ff @(posedge clock or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         rx_sh_q <= 32'h00000000;
         bit_cnt_q <= 6'h00;
         rx_crc_q <= `DIC_CRC_INIT;
      end else if (cs_fall) begin
         bit_cnt_q <= 6'h00;
         rx_crc_q <= `DIC_CRC_INIT;
      end else if (sclk_fall && !cs_n_s) begin
         rx_sh_q <= {rx_sh_q[30:0], sdi_s};
         bit_cnt_q <= rx_cnt_next;
         if (bit_cnt_q < `DIC_FRAME_BITS) begin
            rx_crc_q <= crc_step(rx_crc_q, sdi_s);
         end
      end
   end

   // Register writes and read capture
   always_ff @(posedge clock or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         code_q <= `DIC_RST_CODE;
         cfg_q <= `DIC_RST_CFG;
         raddr_q <= 7'h00;
         rdata_q <= 16'h0000;
      end else begin
         if (wr_en && hit(addr, `DIC_OFF_CODE)) begin
            code_q <= wdata;
         end
         if (wr_en && hit(addr, `DIC_OFF_CFG)) begin
            cfg_q <= wdata;
         end
         if (rd_en) begin
            raddr_q <= addr;
            rdata_q <= hit(addr, `DIC_OFF_CODE) ? code_q :
                       hit(addr, `DIC_OFF_CFG) ? cfg_q : 16'h0000;
         end
      end
   end

   // Transmit shifter; read data return in the next frame
   assign tx_shift = !cs_n_s &&
                     (cfg_q[`DIC_B_EARLY] ? sclk_fall : (sclk_rise && launched_q));
   assign tx_idx_next = (tx_idx_q == 6'h3F) ? tx_idx_q : tx_idx_q + 6'h01;
   assign tx_bit = (tx_idx_q < `DIC_FRAME_BITS) ? tx_sh_q[31] : tx_crc_q[7];

   always_ff @(posedge clock or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         tx_sh_q <= 32'h00000000;
         tx_idx_q <= 6'h00;
         tx_crc_q <= `DIC_CRC_INIT;
         launched_q <= 1'b0;
      end else if (cs_fall) begin
         tx_sh_q <= {1'b0, raddr_q, rdata_q, 8'h00};
         tx_idx_q <= 6'h00;
         tx_crc_q <= `DIC_CRC_INIT;
         launched_q <= 1'b0;
      end else if (!cs_n_s) begin
         if (sclk_rise) begin
            launched_q <= 1'b1;
         end
         if (tx_shift) begin
            tx_sh_q <= {tx_sh_q[30:0], 1'b0};
            tx_idx_q <= tx_idx_next;
            tx_crc_q <= (tx_idx_q < `DIC_FRAME_BITS) ? crc_step(tx_crc_q, tx_sh_q[31]) :
                        {tx_crc_q[6:0], 1'b0};
         end
      end
   end

   // Consecutive CRC failure count
   assign fail_next = {1'b0, fail_cnt_q} + 5'h01;
   assign fail_limit = 5'h01 << cfg_q[`DIC_F_LIMIT];
   assign fail_hit = (fail_next >= fail_limit);

   always_ff @(posedge clock or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         fail_cnt_q <= 4'h0;
         crc_error_q <= 1'b0;
      end else begin
         if (crc_fail_evt) begin
            fail_cnt_q <= fail_hit ? 4'h0 : fail_next[3:0];
         end else if (crc_pass_evt) begin
            fail_cnt_q <= 4'h0;
         end
         // A failure that reaches the limit beats a clear in the same cycle
         if (crc_fail_evt && fail_hit) begin
            crc_error_q <= 1'b1;
         end else if (crc_error_clear) begin
            crc_error_q <= 1'b0;
         end
      end
   end

   // Interrupt shaping and pins
   assign irq_active = cfg_q[`DIC_B_TRIG] ? irq_event : (pulse_q != 8'h00);
   assign brk_mode = cfg_q[`DIC_B_BAUD] && !cfg_q[`DIC_B_UART_OFF];

   always_ff @(posedge clock or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         irq_last_q <= 1'b0;
         pulse_q <= 8'h00;
         irq_pin_o <= 1'b1;
         irq_pin_oe <= 1'b0;
         serial_tx_pin_irq <= 1'b0;
         clear_active <= 1'b0;
         spi_sdo_o <= 1'b0;
         spi_sdo_oe <= 1'b0;
      end else begin
         irq_last_q <= irq_event;
         if (irq_event && !irq_last_q) begin
            pulse_q <= PULSE_CYC;
         end else if (pulse_q != 8'h00) begin
            pulse_q <= pulse_q - 8'h01;
         end
         irq_pin_o <= cfg_q[`DIC_B_POL] ? irq_active : !irq_active;
         irq_pin_oe <= cfg_q[`DIC_B_PIN_EN];
         serial_tx_pin_irq <= cfg_q[`DIC_B_BRK_IRQ] && brk_mode && irq_active;
         clear_active <= cfg_q[`DIC_B_CLR_EN] && brk_mode && sdi_s;
         spi_sdo_o <= tx_bit;
         spi_sdo_oe <= !cfg_q[`DIC_B_TRI] && !cs_n_s;
      end
   end

   // Control outputs
   assign output_code = code_q;
   assign crc_error = crc_error_q;
   assign crc_check_on = crc_en;
   assign serial_port_enable = !cfg_q[`DIC_B_UART_OFF];
   assign break_mode_link = brk_mode;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync_n_q);

   sequence irq_rise_s;
      irq_event && !irq_last_q && !cfg_q[`DIC_B_TRIG];
   endsequence

   sequence edge_mode_hold_s;
      !cfg_q[`DIC_B_TRIG] [*8];
   endsequence

   sequence fail_short_s;
      crc_fail_evt && !fail_hit && !crc_error_q;
   endsequence

   code_write_a: assert property (wr_en && hit(addr, `DIC_OFF_CODE)
      |=> output_code == $past(wdata))
      else $error("output code write lost");
   crc_limit_a: assert property ($rose(crc_error_q)
      |-> $past(crc_fail_evt) && $past(fail_hit))
      else $error("crc flag set before limit");
   crc_early_a: assert property (fail_short_s |=> !crc_error_q)
      else $error("crc flag set on short run");
   break_irq_a: assert property (!cfg_q[`DIC_B_BRK_IRQ] || !brk_mode
      |=> !serial_tx_pin_irq)
      else $error("break interrupt while disabled");
   pin_enable_a: assert property (!cfg_q[`DIC_B_PIN_EN] |=> !irq_pin_oe)
      else $error("interrupt pin driven while disabled");
   clear_pin_a: assert property (cfg_q[`DIC_B_CLR_EN] && brk_mode && sdi_s
      |=> clear_active)
      else $error("clear input ignored");
   uart_off_a: assert property (cfg_q[`DIC_B_UART_OFF]
      |-> !break_mode_link && !serial_port_enable)
      else $error("uart active while off");
   slow_baud_a: assert property (!cfg_q[`DIC_B_BAUD] |-> !break_mode_link)
      else $error("break mode at slow rate");
   crc_skip_a: assert property (!crc_en |-> !crc_fail_evt && !crc_pass_evt)
      else $error("crc checked while disabled");
   irq_high_a: assert property (cfg_q[`DIC_B_TRIG] && cfg_q[`DIC_B_POL] && irq_event
      |=> irq_pin_o)
      else $error("active high interrupt not asserted");
   irq_low_a: assert property (cfg_q[`DIC_B_TRIG] && !cfg_q[`DIC_B_POL] && irq_event
      |=> !irq_pin_o)
      else $error("active low interrupt not asserted");
   edge_pulse_a: assert property (irq_rise_s ##1 edge_mode_hold_s
      |-> $past(irq_active, 7) && $past(irq_active))
      else $error("edge pulse too short");
   sdo_hiz_a: assert property (cfg_q[`DIC_B_TRI] |=> !spi_sdo_oe)
      else $error("sdo driven while tristated");
   sdo_drive_a: assert property (!cfg_q[`DIC_B_TRI] && !cs_n_s |=> spi_sdo_oe)
      else $error("sdo not driven in frame");
   launch_edge_a: assert property (tx_shift
      |-> (cfg_q[`DIC_B_EARLY] ? sclk_fall : sclk_rise))
      else $error("sdo launched on wrong edge");
   cfg_reset_a: assert property ($rose(rst_sync_n_q) |-> cfg_q == `DIC_RST_CFG)
      else $error("config reset value wrong");
   fail_restart_a: assert property (crc_pass_evt |=> fail_cnt_q == 4'h0)
      else $error("fail count not restarted");
endmodule

// *** test/dic_host_model.sv ***
// Host-side SPI master model for the register bank pins
`timescale 1ns/10ps
module dic_host_model (
   // Clock
   input wire logic clock,
   // SPI pins
   input wire logic spi_sdo_o,
   input wire logic spi_sdo_oe,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_sdi
);
   logic early = 1'b0;
   logic oe_seen = 1'b0;
   logic sdo_line;
   // A released line must never pass for held data
   assign sdo_line = spi_sdo_oe ? spi_sdo_o : !spi_sdo_o;
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b0;
   end
   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0] c;
      c = 8'hFF;
      for (int i = 23; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      end
      return c;
   endfunction
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic set_sdi(input logic v);
      @(posedge clock);
      spi_sdi <= v;
   endtask
   // Clock stands low between frames; a bad check byte flips bits of it
   task automatic frame(input logic [23:0] cmd, input logic [7:0] flip, input int nbits,
                        output logic [31:0] rx);
      logic [31:0] tx;
      logic [31:0] rx_rise;
      logic [31:0] rx_fall;
      tx = {cmd, crc8(cmd) ^ flip};
      rx_rise = 32'h0000_0000;
      rx_fall = 32'h0000_0000;
      oe_seen = 1'b0;
      @(posedge clock);
      spi_cs_n <= 1'b0;
      // SDI moves with the rising edge so it stands across the falling capture
      for (int i = 0; i < nbits; i++) begin
         wait_clk(8);
         rx_rise = {rx_rise[30:0], sdo_line};
         spi_sdi <= tx[31 - i];
         spi_sclk <= 1'b1;
         wait_clk(8);
         rx_fall = {rx_fall[30:0], sdo_line};
         oe_seen = oe_seen | spi_sdo_oe;
         spi_sclk <= 1'b0;
      end
      wait_clk(8);
      spi_cs_n <= 1'b1;
      wait_clk(12);
      // Early launch is read half a clock ahead
      rx = early ? rx_rise : rx_fall;
   endtask
endmodule

// *** test/test_dic_config_regs.sv ***
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
module test_dic_config_regs;
   logic clock;
   logic rst_n;
   logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo_o, spi_sdo_oe;
   logic irq_event, irq_pin_o, irq_pin_oe, timer_out, clk_out_o, clk_out_oe;
   logic crc_error_clear, crc_error, crc_check_on, clear_active;
   logic serial_port_enable, break_mode_link, serial_tx_pin_irq;
   logic [15:0] output_code;
   logic [31:0] rx;
   int errors = 0;
   int samples_checked = 0;
   int nb = 32;

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   dic_config_regs dut (.clock(clock), .rst_n(rst_n), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo_o(spi_sdo_o),
      .spi_sdo_oe(spi_sdo_oe), .irq_event(irq_event), .irq_pin_o(irq_pin_o),
      .irq_pin_oe(irq_pin_oe), .timer_out(timer_out), .clk_out_o(clk_out_o),
      .clk_out_oe(clk_out_oe), .crc_error_clear(crc_error_clear), .crc_error(crc_error),
      .crc_check_on(crc_check_on), .output_code(output_code), .clear_active(clear_active),
      .serial_port_enable(serial_port_enable), .break_mode_link(break_mode_link),
      .serial_tx_pin_irq(serial_tx_pin_irq));

   dic_host_model host (.clock(clock), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe(spi_sdo_oe),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi));

   task automatic finish_test();
      if (errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Outputs are read mid-cycle, clear of the updating edge
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      host.frame({1'b0, a, d}, 8'h00, nb, rx);
   endtask

   // The answer only arrives in the frame after the request
   task automatic rd_check(input logic [6:0] a, input logic [15:0] d);
      logic [23:0] resp;
      resp = {1'b0, a, d};
      host.frame({1'b1, a, 16'h0000}, 8'h00, nb, rx);
      host.frame({1'b1, 7'h00, 16'h0000}, 8'h00, nb, rx);
      check(rx, (nb == 32) ? {resp, host.crc8(resp)} : {8'h00, resp});
   endtask

   task automatic irq_step(input logic ev, input int n, input logic exp);
      @(posedge clock);
      irq_event <= ev;
      settle(n);
      check(irq_pin_o, exp);
   endtask

   task automatic irq_hit(input logic [15:0] c, input logic exp);
      logic seen;
      wr(7'h02, c);
      @(posedge clock);
      irq_event <= 1'b1;
      seen = 1'b0;
      repeat (40) begin
         @(negedge clock);
         seen = seen | serial_tx_pin_irq;
      end
      @(posedge clock);
      irq_event <= 1'b0;
      settle(30);
      check(seen, exp);
   endtask

   task automatic t_reset();
      check(output_code, 16'h0000);
      check({crc_check_on, serial_port_enable, break_mode_link}, 3'b111);
      check({irq_pin_oe, clk_out_oe, spi_sdo_oe, irq_pin_o}, 4'b0001);
      wr(7'h01, 16'h0000);
      check(host.oe_seen, 1'b0);
      wr(7'h02, 16'h0034);
      rd_check(7'h02, 16'h0034);
      check(host.oe_seen, 1'b1);
   endtask

   task automatic t_code();
      wr(7'h01, 16'hA5C3);
      check(output_code, 16'hA5C3);
      rd_check(7'h01, 16'hA5C3);
      rd_check(7'h03, 16'h0000);
      wr(7'h02, 16'h0035);
      host.early = 1'b1;
      rd_check(7'h02, 16'h0035);
      wr(7'h02, 16'h0034);
      host.early = 1'b0;
   endtask

   task automatic t_crc();
      int n;
      for (int lim = 0; lim < 4; lim++) begin
         n = 1 << lim;
         wr(7'h02, {lim[1:0], 14'h0034});
         repeat (n - 1) host.frame(24'h01FFFF, 8'h5A, 32, rx);
         wr(7'h01, lim[15:0] + 16'h0001);
         repeat (n - 1) host.frame(24'h01FFFF, 8'h5A, 32, rx);
         check(crc_error, 1'b0);
         host.frame(24'h01FFFF, 8'h5A, 32, rx);
         check(crc_error, 1'b1);
         check(output_code, lim + 1);
         @(posedge clock);
         crc_error_clear <= 1'b1;
         @(posedge clock);
         crc_error_clear <= 1'b0;
         settle(2);
         check(crc_error, 1'b0);
      end
      wr(7'h02, 16'h0024);
      check(crc_check_on, 1'b0);
      nb = 24;
      wr(7'h01, 16'h0F0F);
      check(output_code, 16'h0F0F);
      rd_check(7'h02, 16'h0024);
      wr(7'h02, 16'h0034);
      nb = 32;
      check(crc_check_on, 1'b1);
   endtask

   task automatic t_clock_out_divider();
      int cnt;
      logic prev;
      logic high;
      for (int d = 1; d < 4; d++) begin
         wr(7'h02, {2'b00, d[3:0], 10'h034});
         host.wait_clk(200);
         cnt = 0;
         prev = clk_out_o;
         // About 20 us: 25 periods at full rate
         repeat (4069) begin
            @(negedge clock);
            cnt += (clk_out_o && !prev) ? 1 : 0;
            prev = clk_out_o;
         end
         check(clk_out_oe, 1'b1);
         check(cnt + 1 >= (50 >> d) && cnt <= (50 >> d) + 1, 1'b1);
      end
      for (int d = 12; d < 15; d++) begin
         wr(7'h02, {2'b00, d[3:0], 10'h034});
         high = 1'b0;
         repeat (200) begin
            @(negedge clock);
            high = high | clk_out_o;
         end
         check({clk_out_oe, high}, 2'b10);
      end
      wr(7'h02, 16'h0034);
      check(clk_out_oe, 1'b0);
      wr(7'h02, 16'h3C34);
      for (int v = 1; v >= 0; v--) begin
         @(posedge clock);
         timer_out <= v[0];
         settle(3);
         check(clk_out_o, v[0]);
      end
   endtask

   task automatic t_irq();
      wr(7'h02, 16'h0134);
      check(irq_pin_oe, 1'b1);
      irq_step(1'b1, 30, 1'b0);
      irq_step(1'b0, 3, 1'b1);
      wr(7'h02, 16'h013C);
      irq_step(1'b1, 3, 1'b1);
      irq_step(1'b0, 3, 1'b0);
      wr(7'h02, 16'h0138);
      irq_step(1'b1, 5, 1'b1);
      settle(25);
      check(irq_pin_o, 1'b0);
      irq_step(1'b0, 3, 1'b0);
      wr(7'h02, 16'h0034);
      check(irq_pin_oe, 1'b0);
   endtask

   task automatic t_uart();
      logic [15:0] cfg [4] = '{16'h0034, 16'h0014, 16'h0074, 16'h0054};
      logic [1:0] exp [4] = '{2'b11, 2'b10, 2'b00, 2'b00};
      for (int i = 0; i < 4; i++) begin
         wr(7'h02, cfg[i]);
         check({serial_port_enable, break_mode_link}, exp[i]);
      end
      wr(7'h02, 16'h00B4);
      host.set_sdi(1'b1);
      settle(6);
      check(clear_active, 1'b1);
      wr(7'h02, 16'h0094);
      host.set_sdi(1'b1);
      settle(6);
      check(clear_active, 1'b0);
      irq_hit(16'h0034, 1'b0);
      irq_hit(16'h0234, 1'b1);
   endtask

   initial begin
      rst_n = 1'b0;
      irq_event = 1'b0;
      timer_out = 1'b0;
      crc_error_clear = 1'b0;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      settle(8);
      t_reset();
      t_code();
      t_crc();
      t_clock_out_divider();
      t_irq();
      t_uart();
      finish_test();
   end

   // Whole run needs roughly 52k cycles
   initial begin
      #450000;
      errors++;
      finish_test();
   end
endmodule
